// >>> src/led_channel.sv
// one LED pin: stretch, blink phase and function select
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_channel
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      src,
    input  wire led_ctrl_pkg::led_mode_type mode,
    input  wire logic                      disable_out,
    input  wire logic                      stretch_en,
    input  wire logic [3:0]                blink_len,
    input  wire logic                      slow_tick,
    output logic                           pin_out,
    output logic                           pin_oe_n
);
    logic [3:0] stretch_cnt_reg;
    logic [3:0] phase_cnt_reg;
    logic       phase_on_reg;
    logic       active;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stretch_cnt_reg <= 4'h0;
        else if (src)
            stretch_cnt_reg <= blink_len;
        else if (slow_tick && stretch_cnt_reg != 4'h0)
            stretch_cnt_reg <= stretch_cnt_reg - 4'h1;
    end

    assign active = src | (stretch_en & (stretch_cnt_reg != 4'h0));

    // each phase lasts blink_len slow ticks
    // toggle while active, restart lit when idle
    always_ff @(posedge clk)
    begin
        if (!rst_n || !active)
        begin
            phase_on_reg  <= 1'b1;
            phase_cnt_reg <= blink_len;
        end
        else if (slow_tick)
        begin
            // a zero length is treated as one tick, never a stuck phase
            if (phase_cnt_reg <= 4'h1)
            begin
                phase_on_reg  <= ~phase_on_reg;
                phase_cnt_reg <= blink_len;
            end
            else
                phase_cnt_reg <= phase_cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end
        else
        begin
            unique case (mode)
                led_ctrl_pkg::LED_OFF:
                begin
                    pin_out  <= 1'b0;
                    pin_oe_n <= disable_out;
                end
                led_ctrl_pkg::LED_BLINK:
                begin
                    pin_out  <= active & phase_on_reg;
                    pin_oe_n <= disable_out;
                end
                led_ctrl_pkg::LED_STEADY:
                begin
                    pin_out  <= active;
                    pin_oe_n <= disable_out;
                end
                // open drain: pull low when lit, release otherwise
                led_ctrl_pkg::LED_OPEN_DRAIN:
                begin
                    pin_out  <= 1'b0;
                    pin_oe_n <= disable_out | ~active;
                end
            endcase
        end
    end

    a_off_dark: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == led_ctrl_pkg::LED_OFF && !disable_out) |=> (!pin_out && !pin_oe_n))
        else $error("off mode did not drive the pin low");
    a_steady_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == led_ctrl_pkg::LED_STEADY && !disable_out) |=> (pin_out == $past(active)))
        else $error("steady mode does not follow the source");
    a_blink_dark: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == led_ctrl_pkg::LED_BLINK && !active) |=> !pin_out)
        else $error("blink mode lit without a source");
    a_stretch_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (stretch_en && $past(src) && !src && $past(blink_len) != 4'h0) |-> active)
        else $error("stretched source dropped at once");
    a_phase_waits_tick: assert property (@(posedge clk) disable iff (!rst_n)
        (active && !slow_tick) |=> $stable(phase_on_reg))
        else $error("blink phase changed without a slow tick");
endmodule // led_channel

// >>> src/led_ctrl_map.svh
// register offsets, field positions, reset values and timing for the LED block
`ifndef LED_CTRL_MAP_SVH
`define LED_CTRL_MAP_SVH

`define SLOW_LOW_ADDR        16'hA82A
`define SLOW_HIGH_ADDR       16'hA82B
`define FUNC_CTRL_ADDR       16'hA83B
`define SRC_STATUS_ADDR      16'hA83C
`define SRC_STATUS_HIGH_ADDR 16'hA83D
`define STRETCH_CTRL_ADDR    16'hA8EC
`define BLINK_BASE_ADDR      16'hA820
`define MASK_BASE_ADDR       16'hA828

`define FUNC_CTRL_RESET      16'h4924
`define SLOW_HIGH_RESET      8'hFF
`define SLOW_LOW_RESET       16'hFFFF
`define BLINK_RESET          4'h4

`define FIRST_DISABLE_BIT    2
`define SECOND_DISABLE_BIT   5
`define GATE_BIT             15
`define STRETCH_LSB          5
`define SRC_TEN_GIG_BIT      7
`define SRC_LED_ON_BIT       5
`define SRC_TX_BIT           2
`define SRC_RX_BIT           1
`define SRC_FIVE_G_BIT       3
`define SRC_TWO_HALF_G_BIT   2

`define CLK_PERIOD_NS        100
`define SLOW_UNIT_NS         10
`define SLOW_STEP            (`CLK_PERIOD_NS / `SLOW_UNIT_NS)

`endif

// >>> src/led_ctrl_pkg.sv
// types shared by the LED controller files
package led_ctrl_pkg;
    typedef enum logic [1:0]
    {
        LED_OFF        = 2'b00,
        LED_BLINK      = 2'b01,
        LED_STEADY     = 2'b10,
        LED_OPEN_DRAIN = 2'b11
    } led_mode_type;
endpackage

// >>> src/led_status_ctrl.sv
// status LED controller: registers, slow clock and two LED pins
//
// What this block does
// - second LED disable bit, resets to one
// - function codes: off, blink, open-drain
// - code 10 lights LED while source active
// - first LED disable at bit 2, resets one
// - source bit 7 shows 10G copper link
// - bits 4:3 show 1G or 100M link
// - bit 15 gates RX/TX activity into sources
// - high source bits show 5G and 2.5G
// - stretch enables lengthen each LED's source
// - slow clock period is count plus one
// - blink count sets on and off length
// - per-LED mask bits enable status sources
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module led_status_ctrl
#(
    parameter int LED_COUNT = 2
)
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    input  wire logic        LINK_TEN_GIG_UP,
    input  wire logic [1:0]  LINK_STATE,
    input  wire logic        LINK_FIVE_GIG_UP,
    input  wire logic        LINK_TWO_HALF_GIG_UP,
    input  wire logic        RX_ACTIVITY,
    input  wire logic        TX_ACTIVITY,
    output logic             FIRST_LED_OUT,
    output logic             FIRST_LED_OE_N,
    output logic             SECOND_LED_OUT,
    output logic             SECOND_LED_OE_N
);
    localparam logic [24:0] SLOW_STEP = 25'(`SLOW_STEP);

    logic [15:0] func_ctrl_reg;
    logic [15:0] stretch_ctrl_reg;
    logic [7:0]  slow_high_reg;
    logic [15:0] slow_low_reg;
    logic [15:0] src_status_reg;
    logic [15:0] src_status_high_reg;
    logic [24:0] slow_acc_reg;
    logic [24:0] slow_acc_next;
    logic [24:0] slow_period;
    logic        slow_tick_reg;
    logic [3:0]  blink_reg [LED_COUNT];
    logic [15:0] mask_reg  [LED_COUNT];
    logic [LED_COUNT-1:0] led_src;
    logic [LED_COUNT-1:0] pin_out;
    logic [LED_COUNT-1:0] pin_oe_n;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            func_ctrl_reg <= `FUNC_CTRL_RESET;
        else if (REG_WR && REG_ADDR == `FUNC_CTRL_ADDR)
            func_ctrl_reg <= REG_WDATA;
    end

    // reserved stretch bits kept as written
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            stretch_ctrl_reg <= 16'h0000;
        else if (REG_WR && REG_ADDR == `STRETCH_CTRL_ADDR)
            stretch_ctrl_reg <= REG_WDATA;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            slow_high_reg <= `SLOW_HIGH_RESET;
            slow_low_reg  <= `SLOW_LOW_RESET;
        end
        else if (REG_WR && REG_ADDR == `SLOW_HIGH_ADDR)
            slow_high_reg <= REG_WDATA[7:0];
        else if (REG_WR && REG_ADDR == `SLOW_LOW_ADDR)
            slow_low_reg <= REG_WDATA;
    end

    // period in 10 ns units; each clock adds its own length
    assign slow_period   = {1'b0, slow_high_reg, slow_low_reg} + 25'h0000001;
    assign slow_acc_next = slow_acc_reg + SLOW_STEP;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            slow_acc_reg  <= 25'h0000000;
            slow_tick_reg <= 1'b0;
        end
        else if (REG_WR && (REG_ADDR == `SLOW_HIGH_ADDR || REG_ADDR == `SLOW_LOW_ADDR))
        begin
            // restart on a new count: a shortened period would otherwise burst ticks
            slow_acc_reg  <= 25'h0000000;
            slow_tick_reg <= 1'b0;
        end
        else if (slow_acc_next >= slow_period)
        begin
            slow_acc_reg  <= slow_acc_next - slow_period;
            slow_tick_reg <= 1'b1;
        end
        else
        begin
            slow_acc_reg  <= slow_acc_next;
            slow_tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            src_status_reg      <= 16'h0000;
            src_status_high_reg <= 16'h0000;
        end
        else
        begin
            src_status_reg <= 16'h0000;
            src_status_reg[`SRC_TEN_GIG_BIT] <= LINK_TEN_GIG_UP;
            src_status_reg[`SRC_LED_ON_BIT]  <= 1'b1;
            src_status_reg[4:3] <= LINK_STATE;
            // activity passes only when gated in
            src_status_reg[`SRC_TX_BIT] <= TX_ACTIVITY & stretch_ctrl_reg[`GATE_BIT];
            src_status_reg[`SRC_RX_BIT] <= RX_ACTIVITY & stretch_ctrl_reg[`GATE_BIT];
            src_status_high_reg <= 16'h0000;
            src_status_high_reg[`SRC_FIVE_G_BIT]     <= LINK_FIVE_GIG_UP;
            src_status_high_reg[`SRC_TWO_HALF_G_BIT] <= LINK_TWO_HALF_GIG_UP;
        end
    end

    genvar i;
    generate
        for (i = 0; i < LED_COUNT; i++)
        begin : g_led
            always_ff @(posedge CLK)
            begin
                if (!RST_N)
                begin
                    blink_reg[i] <= `BLINK_RESET;
                    mask_reg[i]  <= 16'h0000;
                end
                else if (REG_WR && REG_ADDR == `BLINK_BASE_ADDR + 16'(i))
                    blink_reg[i] <= REG_WDATA[3:0];
                else if (REG_WR && REG_ADDR == `MASK_BASE_ADDR + 16'(i))
                    mask_reg[i] <= REG_WDATA;
            end

            assign led_src[i] = |(mask_reg[i] & src_status_reg);

            led_channel u_channel
            (
                .clk         (CLK),
                .rst_n       (RST_N),
                .src         (led_src[i]),
                .mode        (led_ctrl_pkg::led_mode_type'(func_ctrl_reg[3*i+1 -: 2])),
                .disable_out (func_ctrl_reg[3*i+2]),
                .stretch_en  (stretch_ctrl_reg[`STRETCH_LSB+i]),
                .blink_len   (blink_reg[i]),
                .slow_tick   (slow_tick_reg),
                .pin_out     (pin_out[i]),
                .pin_oe_n    (pin_oe_n[i])
            );
        end
    endgenerate

    assign FIRST_LED_OUT   = pin_out[0];
    assign FIRST_LED_OE_N  = pin_oe_n[0];
    assign SECOND_LED_OUT  = pin_out[1];
    assign SECOND_LED_OE_N = pin_oe_n[1];

    // registered read; unmapped addresses read zero
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            REG_RDATA <= 16'h0000;
        else if (REG_RD)
        begin
            REG_RDATA <= 16'h0000;
            if (REG_ADDR == `FUNC_CTRL_ADDR)
                REG_RDATA <= func_ctrl_reg;
            else if (REG_ADDR == `STRETCH_CTRL_ADDR)
                REG_RDATA <= stretch_ctrl_reg;
            else if (REG_ADDR == `SRC_STATUS_ADDR)
                REG_RDATA <= src_status_reg;
            else if (REG_ADDR == `SRC_STATUS_HIGH_ADDR)
                REG_RDATA <= src_status_high_reg;
            else if (REG_ADDR == `SLOW_HIGH_ADDR)
                REG_RDATA <= {8'h00, slow_high_reg};
            else if (REG_ADDR == `SLOW_LOW_ADDR)
                REG_RDATA <= slow_low_reg;
            else
                for (int k = 0; k < LED_COUNT; k++)
                begin
                    if (REG_ADDR == `BLINK_BASE_ADDR + 16'(k))
                        REG_RDATA <= {12'h000, blink_reg[k]};
                    if (REG_ADDR == `MASK_BASE_ADDR + 16'(k))
                        REG_RDATA <= mask_reg[k];
                end
        end
    end

    sequence s_gate_closed;
        !stretch_ctrl_reg[`GATE_BIT];
    endsequence

    a_gate_blocks: assert property (@(posedge CLK) disable iff (!RST_N)
        s_gate_closed |=> (!src_status_reg[`SRC_TX_BIT] && !src_status_reg[`SRC_RX_BIT]))
        else $error("activity passed with the gate closed");
    a_ten_gig_bit: assert property (@(posedge CLK) disable iff (!RST_N)
        1'b1 |=> (src_status_reg[`SRC_TEN_GIG_BIT] == $past(LINK_TEN_GIG_UP)))
        else $error("10G link bit wrong");
    a_link_state: assert property (@(posedge CLK) disable iff (!RST_N)
        1'b1 |=> (src_status_reg[4:3] == $past(LINK_STATE)))
        else $error("link state field wrong");
    a_high_links: assert property (@(posedge CLK) disable iff (!RST_N)
        1'b1 |=> (src_status_high_reg[3:2] == {$past(LINK_FIVE_GIG_UP), $past(LINK_TWO_HALF_GIG_UP)}))
        else $error("high link bits wrong");
    a_first_disable: assert property (@(posedge CLK) disable iff (!RST_N)
        func_ctrl_reg[`FIRST_DISABLE_BIT] |=> FIRST_LED_OE_N)
        else $error("first LED driven while disabled");
    a_second_disable: assert property (@(posedge CLK) disable iff (!RST_N)
        func_ctrl_reg[`SECOND_DISABLE_BIT] |=> SECOND_LED_OE_N)
        else $error("second LED driven while disabled");
    a_slow_spacing: assert property (@(posedge CLK) disable iff (!RST_N)
        (slow_tick_reg && slow_period >= (SLOW_STEP << 1) && $stable(slow_period)) |=> !slow_tick_reg)
        else $error("slow ticks too close");
endmodule // led_status_ctrl

// >>> tb/led_board_model.sv
// board-side model of one status LED pad with its pull-up resistor
`timescale 1ns/1ps
module led_board_model
(
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pad
);
    // a released pad floats up through the board resistor, never holds old value
    assign pad = pin_oe_n ? 1'h1 : pin_out;
endmodule // led_board_model

// >>> tb/tb_top.sv
// self-checking bench for the status LED controller
`timescale 1ns/1ps
`include "led_ctrl_map.svh"
module tb_top;
    logic        clk         = 1'h0;
    logic        rst_n       = 1'h0;
    logic [15:0] reg_addr    = 16'h0000;
    logic        reg_wr      = 1'h0;
    logic [15:0] reg_wdata   = 16'h0000;
    logic        reg_rd      = 1'h0;
    logic        ten_up      = 1'h0;
    logic [1:0]  link_state  = 2'h0;
    logic        five_up     = 1'h0;
    logic        two_half_up = 1'h0;
    logic        rx_act      = 1'h0;
    logic        tx_act      = 1'h0;
    logic [15:0] reg_rdata;
    logic        led1_out;
    logic        first_led_output_disable;
    logic        led2_out;
    logic        second_led_output_disable;
    logic        pad1;
    logic        pad2;
    logic        last;
    logic [15:0] tmp;
    int          n_mismatch      = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    int          t_prev;
    int          gap[$];

    led_status_ctrl #(.LED_COUNT(2)) i_led_status_ctrl
    (
        .CLK                  (clk),
        .RST_N                (rst_n),
        .REG_ADDR             (reg_addr),
        .REG_WR               (reg_wr),
        .REG_WDATA            (reg_wdata),
        .REG_RD               (reg_rd),
        .REG_RDATA            (reg_rdata),
        .LINK_TEN_GIG_UP      (ten_up),
        .LINK_STATE           (link_state),
        .LINK_FIVE_GIG_UP     (five_up),
        .LINK_TWO_HALF_GIG_UP (two_half_up),
        .RX_ACTIVITY          (rx_act),
        .TX_ACTIVITY          (tx_act),
        .FIRST_LED_OUT        (led1_out),
        .FIRST_LED_OE_N       (first_led_output_disable),
        .SECOND_LED_OUT       (led2_out),
        .SECOND_LED_OE_N      (second_led_output_disable)
    );
    led_board_model i_board_first (.pin_out(led1_out), .pin_oe_n(first_led_output_disable), .pad(pad1));
    led_board_model i_board_second (.pin_out(led2_out), .pin_oe_n(second_led_output_disable), .pad(pad2));

    always #50 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, generous against the roughly 120 cycles the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        wait_cyc(0);
        check({12'h0, pad2, pad1, second_led_output_disable, first_led_output_disable}, 16'h000F); // pins released
        rdc(`FUNC_CTRL_ADDR, 16'h4924); // disables set
        rdc(`SLOW_HIGH_ADDR, 16'h00FF); // count high
        rdc(`SLOW_LOW_ADDR, 16'hFFFF); // count low
        rdc(`BLINK_BASE_ADDR, 16'h0004); // blink length
        rdc(`MASK_BASE_ADDR, 16'h0000); // masks clear
        rdc(`STRETCH_CTRL_ADDR, 16'h0000); // no stretch
        rdc(`SRC_STATUS_ADDR, 16'h0020); // link down
        rdc(16'h1234, 16'h0000); // unmapped reads zero
        wr(`SRC_STATUS_ADDR, 16'hFFFF);
        rdc(`SRC_STATUS_ADDR, 16'h0020); // read-only
        $display("test reset done");
        @(posedge clk);
        ten_up      <= 1'h1;
        link_state  <= 2'h3;
        five_up     <= 1'h1;
        two_half_up <= 1'h1;
        rx_act      <= 1'h1;
        tx_act      <= 1'h1;
        rdc(`SRC_STATUS_ADDR, 16'h00B8); // gigabit code
        rdc(`SRC_STATUS_HIGH_ADDR, 16'h000C); // mid rates
        rd(`STRETCH_CTRL_ADDR, tmp);
        wr(`STRETCH_CTRL_ADDR, tmp | 16'h8000);
        @(posedge clk);
        link_state <= 2'h2;
        rdc(`SRC_STATUS_ADDR, 16'h00B6); // activity passed
        $display("test sources done");
        wr(`MASK_BASE_ADDR, 16'h0080);
        wr(`MASK_BASE_ADDR + 16'h0001, 16'h0080);
        wr(`FUNC_CTRL_ADDR, 16'h491A);
        wait_cyc(2);
        check({12'h0, pad2, second_led_output_disable, first_led_output_disable, led1_out}, 16'h0001); // steady lit
        @(posedge clk);
        ten_up <= 1'h0;
        wait_cyc(2);
        check({12'h0, pad2, second_led_output_disable, first_led_output_disable, led1_out}, 16'h000C); // masked source off
        @(posedge clk);
        ten_up <= 1'h1;
        wr(`FUNC_CTRL_ADDR, 16'h4938);
        wait_cyc(2);
        check({14'h0, first_led_output_disable, led1_out}, 16'h0000); // off mode driven
        check({14'h0, pad2, second_led_output_disable}, 16'h0003); // disable wins
        $display("test modes done");
        wr(`SLOW_HIGH_ADDR, 16'h0000);
        wr(`SLOW_LOW_ADDR, 16'h0013);
        wr(`BLINK_BASE_ADDR, 16'h0002);
        wr(`FUNC_CTRL_ADDR, 16'h4901);
        t_prev = cycles;
        last = led1_out;
        repeat (40)
        begin
            @(negedge clk);
            if (led1_out !== last) // phase edge
            begin
                gap.push_back(cycles - t_prev);
                t_prev = cycles;
                last = led1_out;
            end
        end
        check(16'(gap[2]), 16'h0004); // two ticks dark
        check(16'(gap[3]), 16'h0004); // two ticks lit
        @(posedge clk);
        ten_up <= 1'h0;
        wait_cyc(3);
        check(16'(led1_out), 16'h0000); // idle dark
        $display("test blink done");
        wr(`FUNC_CTRL_ADDR, 16'h4902);
        for (int s = 0; s < 2; s++)
        begin
            if (s == 1)
            begin
                rd(`STRETCH_CTRL_ADDR, tmp);
                wr(`STRETCH_CTRL_ADDR, tmp | 16'h0020);
            end
            @(posedge clk);
            ten_up <= 1'h1;
            @(posedge clk);
            ten_up <= 1'h0;
            wait_cyc(2);
            check(16'(led1_out), 16'(s)); // pulse lengthened only with stretch on
        end
        $display("test stretch done");
        close_out();
    end
endmodule // tb_top
